// File: lsp_frac_div.sv
// feedback n divider: one tick per 2 x (whole + num / den) oscillator edges
// assumes osc_edge is a one-cycle pulse already in the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module lsp_frac_div
   import lsp_pkg::*;
#(
   parameter int W = lsp_pkg::WHOLE_W
)
(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         osc_edge,
   input  wire logic         frac_mode,
   input  wire logic [W-1:0] whole,
   input  wire logic [15:0]  num,
   input  wire logic [15:0]  den,
   output logic              tick
);
   import lsp_pkg::*;

   typedef struct packed
   {
      logic [W+1:0] cnt;
      logic [15:0]  acc;
      logic         tick;
   } lsp_fdiv_s;

   lsp_fdiv_s    q, n;
   logic [16:0]  sum;
   logic         carry;
   logic [W-1:0] whole_eff;

   always_comb
   begin
      n         = q;
      n.tick    = 1'b0;
      sum       = {1'b0, q.acc} + {1'b0, num};
      carry     = frac_mode && (den != 16'h0000) && (sum >= {1'b0, den});
      whole_eff = (whole == '0) ? W'(1) : whole;
      if (osc_edge)
      begin
         if (q.cnt == '0)
         begin
            n.tick = 1'b1;
            // a carry stretches this period by one whole ratio step
            n.cnt  = {1'b0, whole_eff, 1'b0} + (carry ? (W+2)'(1) : (W+2)'(-1));
            if (carry)
               n.acc = 16'(sum - {1'b0, den});
            else if (frac_mode && den != 16'h0000)
               n.acc = sum[15:0];
            else
               n.acc = 16'h0000;
         end
         else
            n.cnt = q.cnt - (W+2)'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= n;
   end

   assign tick = q.tick;

endmodule
`default_nettype wire

// File: lsp_host_model.sv
// serial host: one 24-bit frame per call, msb first
// assumes the bench resolves the shared sdio line from the device enable
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model
(
   output logic      sclk,
   output logic      cs_n,
   output logic      sdo,
   input  wire logic sdi
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdo  = 1'b0;
   end
   // sclk stands low between frames; a released line shows the inverse of its last bit
   task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] q);
      logic [23:0] f;
      f = {a, rw, d};
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         sdo = (rw && i < 16) ? ~sdo : f[i];
         #100 sclk = 1'b1;
         #95 q = {q[14:0], sdi};
         #5 sclk = 1'b0;
      end
      #100 cs_n = 1'b1;
      sdo = ~sdo;
      #200;
   endtask
endmodule
`default_nettype wire

// File: lsp_pkg.sv
// lo synthesizer control: shared constants, types and helpers
// assumes every user compiles this package first
`default_nettype none
package lsp_pkg;

   // ----------------------------------------------------------------
   // register addresses on the serial port
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_LO_EN  = 7'h01;
   localparam logic [6:0] ADDR_WHOLE  = 7'h02;
   localparam logic [6:0] ADDR_NUM    = 7'h03;
   localparam logic [6:0] ADDR_DEN    = 7'h04;
   localparam logic [6:0] ADDR_REFMON = 7'h21;
   localparam logic [6:0] ADDR_LOPATH = 7'h22;
   localparam logic [6:0] ADDR_TRIM   = 7'h49;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int QUAD_EN_BIT  = 9;   // lo_enables_config
   localparam int LO_EN_LSB    = 0;   // lo_enables_config, 7 bits
   localparam int DIV_MODE_BIT = 11;  // n_whole_value_reg, 1 = integer
   localparam int WHOLE_W      = 11;  // n_whole_value_reg [10:0]
   localparam int REF_SCL_LSB  = 0;   // ref_and_monitor_config [2:0]
   localparam int POL_BIT      = 3;   // phase_detector_sense, 1 = negative
   localparam int MON_LSB      = 4;   // ref_and_monitor_config [6:4]
   localparam int CORE_LSB     = 0;   // lo_path_config [2:0]
   localparam int HALF1_BIT    = 3;   // lo_halving_stage_one_enable
   localparam int HALF2_BIT    = 4;   // lo_halving_stage_two_enable
   localparam int DRV_LSB      = 6;   // lo_output_drive_level [7:6]

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_LO_EN  = 16'h0000;
   localparam logic [15:0] RST_WHOLE  = 16'h0000; // fractional mode
   localparam logic [15:0] RST_NUM    = 16'h0000;
   localparam logic [15:0] RST_DEN    = 16'h0000;
   localparam logic [15:0] RST_REFMON = 16'h0000; // monitor = lock detect
   localparam logic [15:0] RST_LOPATH = 16'h0000;
   localparam logic [15:0] RST_TRIM   = 16'h0000;

   // ----------------------------------------------------------------
   // timing and frame
   // ----------------------------------------------------------------
   localparam int CAL_PFD_CYCLES_DEF         = 94208;
   localparam logic [7:0] LOCK_PFD_CYCLES_DEF = 8'h20;
   localparam int ADDR_BITS = 7;
   localparam int DATA_BITS = 16;

   typedef enum logic [2:0]
   {
      REF_X1 = 3'b000,
      REF_X2 = 3'b001,
      REF_D2 = 3'b010,
      REF_D4 = 3'b011,
      REF_D8 = 3'b100
   } lsp_ref_e;

   typedef enum logic [2:0]
   {
      MON_LOCK = 3'b000,
      MON_REF  = 3'b001,
      MON_FB   = 3'b010,
      MON_CAL  = 3'b011
   } lsp_mon_e;

   typedef enum logic [1:0]
   {
      SPI_IDLE = 2'b00,
      SPI_ADDR = 2'b01,
      SPI_DATA = 2'b10
   } lsp_spi_e;

   typedef struct packed
   {
      logic [6:0]  addr;
      logic [15:0] data;
   } lsp_wr_s;

   typedef struct packed
   {
      logic [3:0] vco_core_en;
      logic       ext_lo_mode;
      logic [6:0] lo_enables;
      logic       quad_div_en;
      logic       lo_halving_stage_one_enable;
      logic       lo_halving_stage_two_enable;
      logic [1:0] lo_output_drive_level;
   } lsp_lo_ctl_s;

   typedef struct packed
   {
      logic up;
      logic dn;
   } lsp_pump_s;

   // s[0] is the first synchroniser stage and is never looked at here
   function automatic logic sig_rise(input logic [2:0] s);
      return s[1] & ~s[2];
   endfunction

   function automatic logic sig_fall(input logic [2:0] s);
      return ~s[1] & s[2];
   endfunction

endpackage
`default_nettype wire

// File: lsp_pll_control.sv
// lo synthesizer control: registers, reference scaling, phase detector,
// feedback divider, band calibration, lo divider chain and monitor pin
// assumes all clock and serial inputs are asynchronous pins sampled by
// clk_sys, and that they run well below half of clk_sys
//
// Notes on behaviour
// - reference is divided by 2, 4, 8 or multiplied by 1, 2 first
// - detector pulses up or down by which input leads, sense by polarity
// - core select 011..000 picks four oscillator cores, rising band
// - core select with top bit set means external lo, oscillator bypassed
// - two halving stages give lo division 1, 2 or 4
// - quadrature divider halves again, giving in-phase and quadrature lo
// - whole register bit 11 picks integer mode; fractional after reset
// - ratio is whole plus numerator over denominator, registers 02..04
// - detector rate is oscillator rate over twice the ratio
// - writing whole, numerator or denominator starts band calibration
// - calibration lasts 94,208 detector cycles, then the loop settles
// - monitor select bits 6..4 choose monitor pin; default lock detect
// - drive level bits 7..6 pick four lo output amplitudes
// - serial frame is 7 address bits, read flag, 16 data, msb first
`timescale 1ns/1ps
`default_nettype none
module lsp_pll_control
   import lsp_pkg::*;
#(
   parameter int         CAL_PFD_CYCLES  = lsp_pkg::CAL_PFD_CYCLES_DEF,
   parameter logic [7:0] LOCK_PFD_CYCLES = lsp_pkg::LOCK_PFD_CYCLES_DEF
)
(
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                spi_sclk,
   input  wire logic                spi_cs_n,
   input  wire logic                spi_sdio_i,
   output logic                     spi_sdio_o,
   output logic                     spi_sdio_oe_n,
   input  wire logic                ref_clk_in,
   input  wire logic                vco_clk_in,
   input  wire logic                ext_lo_in,
   output var lsp_pkg::lsp_pump_s   pump,
   output var lsp_pkg::lsp_lo_ctl_s lo_ctl,
   output logic                     lo_i,
   output logic                     lo_q,
   output logic                     int_mode,
   output logic                     cal_busy,
   output logic                     pll_locked,
   output logic                     monitor_output_pin
);
   import lsp_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [15:0] r_lo_en;
      logic [15:0] r_whole;
      logic [15:0] r_num;
      logic [15:0] r_den;
      logic [15:0] r_refmon;
      logic [15:0] r_lopath;
      logic [15:0] r_trim;
      logic [2:0]  ref_s;
      logic [2:0]  vco_s;
      logic [2:0]  ext_s;
      logic [2:0]  ref_cnt;
      logic        up;
      logic        dn;
      logic        cal_busy;
      logic [16:0] cal_cnt;
      logic [7:0]  lock_cnt;
      logic        locked;
      logic [2:0]  lo_cnt;
      logic [1:0]  quad;
      logic        ref_tog;
      logic        fb_tog;
      logic        mon;
   } lsp_top_s;

   lsp_top_s    q, n;

   logic        wr_valid;
   lsp_wr_s     wr;
   logic [6:0]  rd_addr;
   logic [15:0] rd_data;
   logic        fb_tick;
   logic        ref_edge;
   logic        ref_tick;
   logic        ext_mode;
   logic        vco_edge;
   logic        src_evt;
   logic [2:0]  lo_last;
   logic        nu;
   logic        nd;

   // last count of the reference prescaler for each divide setting
   function automatic logic [2:0] ref_last(input logic [2:0] scl);
      case (scl)
         REF_D2:  return 3'h1;
         REF_D4:  return 3'h3;
         REF_D8:  return 3'h7;
         default: return 3'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // serial port and feedback divider
   // ----------------------------------------------------------------
   lsp_serial_port u_port
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .sclk      (spi_sclk),
      .cs_n      (spi_cs_n),
      .sdio_i    (spi_sdio_i),
      .sdio_o    (spi_sdio_o),
      .sdio_oe_n (spi_sdio_oe_n),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .wr_valid  (wr_valid),
      .wr        (wr)
   );

   assign ext_mode = q.r_lopath[CORE_LSB+2];
   assign vco_edge = sig_rise(q.vco_s) & ~ext_mode;

   lsp_frac_div #(.W(WHOLE_W)) u_ndiv
   (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .osc_edge  (vco_edge),
      .frac_mode (~q.r_whole[DIV_MODE_BIT]),
      .whole     (q.r_whole[WHOLE_W-1:0]),
      .num       (q.r_num),
      .den       (q.r_den),
      .tick      (fb_tick)
   );

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      case (rd_addr)
         ADDR_LO_EN:  rd_data = q.r_lo_en;
         ADDR_WHOLE:  rd_data = q.r_whole;
         ADDR_NUM:    rd_data = q.r_num;
         ADDR_DEN:    rd_data = q.r_den;
         ADDR_REFMON: rd_data = q.r_refmon;
         ADDR_LOPATH: rd_data = q.r_lopath;
         ADDR_TRIM:   rd_data = q.r_trim;
         default:     rd_data = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n       = q;
      n.ref_s = {q.ref_s[1:0], ref_clk_in};
      n.vco_s = {q.vco_s[1:0], vco_clk_in};
      n.ext_s = {q.ext_s[1:0], ext_lo_in};

      // register writes
      if (wr_valid)
      begin
         case (wr.addr)
            ADDR_LO_EN:  n.r_lo_en  = wr.data;
            ADDR_WHOLE:  n.r_whole  = wr.data;
            ADDR_NUM:    n.r_num    = wr.data;
            ADDR_DEN:    n.r_den    = wr.data;
            ADDR_REFMON: n.r_refmon = wr.data;
            ADDR_LOPATH: n.r_lopath = wr.data;
            ADDR_TRIM:   n.r_trim   = wr.data;
            default:     n.r_trim   = q.r_trim;
         endcase
      end

      // reference scaling; doubling uses both reference edges
      ref_edge = sig_rise(q.ref_s);
      case (q.r_refmon[REF_SCL_LSB+:3])
         REF_X1:  ref_tick = ref_edge;
         REF_X2:  ref_tick = ref_edge | sig_fall(q.ref_s);
         REF_D2,
         REF_D4,
         REF_D8:  ref_tick = ref_edge &&
                     (q.ref_cnt == ref_last(q.r_refmon[REF_SCL_LSB+:3]));
         default: ref_tick = ref_edge;
      endcase
      if (ref_edge)
      begin
         if (q.ref_cnt >= ref_last(q.r_refmon[REF_SCL_LSB+:3]))
            n.ref_cnt = 3'h0;
         else
            n.ref_cnt = q.ref_cnt + 3'h1;
      end

      // phase detector: whichever input arrives first holds its pulse
      // until the other one arrives
      nu = q.up | ref_tick;
      nd = q.dn | fb_tick;
      if (nu && nd)
      begin
         n.up = 1'b0;
         n.dn = 1'b0;
      end
      else
      begin
         n.up = nu;
         n.dn = nd;
      end

      // lock: a run of detector cycles with no pulse left pending
      if (ref_tick)
      begin
         if (q.up || q.dn)
            n.lock_cnt = 8'h00;
         else if (q.lock_cnt != LOCK_PFD_CYCLES)
            n.lock_cnt = q.lock_cnt + 8'h01;
      end

      // band calibration, timed in detector cycles
      if (wr_valid &&
          (wr.addr == ADDR_WHOLE || wr.addr == ADDR_NUM || wr.addr == ADDR_DEN))
      begin
         n.cal_busy = 1'b1;
         n.cal_cnt  = 17'h00000;
         n.lock_cnt = 8'h00;
      end
      else if (q.cal_busy && ref_tick)
      begin
         if (q.cal_cnt == 17'(CAL_PFD_CYCLES - 1))
         begin
            n.cal_busy = 1'b0;
            n.lock_cnt = 8'h00;
         end
         else
            n.cal_cnt = q.cal_cnt + 17'h00001;
      end
      n.locked = ~n.cal_busy && (n.lock_cnt == LOCK_PFD_CYCLES);

      // lo chain: count source edges, step a two-bit johnson counter
      // every 1, 2 or 4 edges, giving a total of 2, 4 or 8 source periods
      src_evt = ext_mode ? (sig_rise(q.ext_s) | sig_fall(q.ext_s))
                         : (sig_rise(q.vco_s) | sig_fall(q.vco_s));
      // widen before adding: a one-bit sum would wrap to zero for divide by 8
      lo_last = (3'h1 << ({1'b0, q.r_lopath[HALF1_BIT]} + {1'b0, q.r_lopath[HALF2_BIT]}))
                - 3'h1;
      if (!q.r_lo_en[QUAD_EN_BIT])
      begin
         n.lo_cnt = 3'h0;
         n.quad   = 2'b00;
      end
      else if (src_evt)
      begin
         if (q.lo_cnt >= lo_last)
         begin
            n.lo_cnt = 3'h0;
            n.quad   = {q.quad[0], ~q.quad[1]};
         end
         else
            n.lo_cnt = q.lo_cnt + 3'h1;
      end

      // monitor pin
      if (ref_tick)
         n.ref_tog = ~q.ref_tog;
      if (fb_tick)
         n.fb_tog = ~q.fb_tog;
      case (q.r_refmon[MON_LSB+:3])
         MON_LOCK: n.mon = n.locked;
         MON_REF:  n.mon = q.ref_tog;
         MON_FB:   n.mon = q.fb_tog;
         MON_CAL:  n.mon = q.cal_busy;
         default:  n.mon = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         q          <= '0;
         q.r_lo_en  <= RST_LO_EN;
         q.r_whole  <= RST_WHOLE;
         q.r_num    <= RST_NUM;
         q.r_den    <= RST_DEN;
         q.r_refmon <= RST_REFMON;
         q.r_lopath <= RST_LOPATH;
         q.r_trim   <= RST_TRIM;
      end
      else
         q <= n;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // negative sense swaps the pump directions
   assign pump.up = q.r_refmon[POL_BIT] ? q.dn : q.up;
   assign pump.dn = q.r_refmon[POL_BIT] ? q.up : q.dn;

   // code 000 is the highest band, so it lights core 3
   always_comb
   begin
      lo_ctl             = '0;
      lo_ctl.ext_lo_mode = ext_mode;
      if (!ext_mode)
         lo_ctl.vco_core_en = 4'h8 >> q.r_lopath[CORE_LSB+:2];
      lo_ctl.lo_enables  = q.r_lo_en[LO_EN_LSB+:7];
      lo_ctl.quad_div_en = q.r_lo_en[QUAD_EN_BIT];
      lo_ctl.lo_halving_stage_one_enable = q.r_lopath[HALF1_BIT];
      lo_ctl.lo_halving_stage_two_enable = q.r_lopath[HALF2_BIT];
      lo_ctl.lo_output_drive_level = q.r_lopath[DRV_LSB+:2];
   end

   assign lo_i               = q.quad[0];
   assign lo_q               = q.quad[1];
   assign int_mode           = q.r_whole[DIV_MODE_BIT];
   assign cal_busy           = q.cal_busy;
   assign pll_locked         = q.locked;
   assign monitor_output_pin = q.mon;

endmodule
`default_nettype wire

// File: lsp_pll_control_assertions.sv
// checker for the lo synthesizer control, bound to its top module
// assumes one clk_sys domain with rst asynchronous, active high
`timescale 1ns/1ps
`default_nettype none
module lsp_pll_control_assertions
   import lsp_pkg::*;
#(
   parameter int         CAL_PFD_CYCLES  = CAL_PFD_CYCLES_DEF,
   parameter logic [7:0] LOCK_PFD_CYCLES = LOCK_PFD_CYCLES_DEF
)
(
   input wire logic                 clk_sys,
   input wire logic                 rst,
   input wire logic                 spi_cs_n,
   input wire logic                 spi_sdio_oe_n,
   input wire lsp_pkg::lsp_pump_s   pump,
   input wire lsp_pkg::lsp_lo_ctl_s lo_ctl,
   input wire logic                 lo_i,
   input wire logic                 lo_q,
   input wire logic                 cal_busy,
   input wire logic                 pll_locked
);
   import lsp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // a detector tick spans many clk_sys cycles, so eight cycles is a safe floor
   sequence s_cal_hold; cal_busy [*8]; endsequence
   sequence s_cs_idle; spi_cs_n [*8]; endsequence
   a_cal_no_lock: assert property (cal_busy |-> !pll_locked)
      else $error("lock shown while calibrating");
   a_cal_floor: assert property ($rose(cal_busy) |-> s_cal_hold)
      else $error("calibration ended too soon");
   a_lock_late: assert property ($fell(cal_busy) |-> !pll_locked [*8])
      else $error("lock right after calibration");
   a_core_onehot: assert property (!lo_ctl.ext_lo_mode |-> $onehot(lo_ctl.vco_core_en))
      else $error("core enables not one-hot");
   a_ext_bypass: assert property (lo_ctl.ext_lo_mode |-> lo_ctl.vco_core_en == 4'h0)
      else $error("core on in external mode");
   a_quad_off: assert property (!lo_ctl.quad_div_en && !$past(lo_ctl.quad_div_en) |-> !lo_i && !lo_q)
      else $error("quadrature lo while splitter off");
   a_quad_lag: assert property ($rose(lo_i) |-> !lo_q)
      else $error("q not lagging i");
   a_pump_excl: assert property (!(pump.up && pump.dn))
      else $error("up and down together");
   a_sdio_idle: assert property (s_cs_idle |-> spi_sdio_oe_n)
      else $error("sdio driven outside a frame");
endmodule
bind lsp_pll_control lsp_pll_control_assertions #(
   .CAL_PFD_CYCLES(CAL_PFD_CYCLES), .LOCK_PFD_CYCLES(LOCK_PFD_CYCLES)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sdio_oe_n(spi_sdio_oe_n),
   .pump(pump), .lo_ctl(lo_ctl), .lo_i(lo_i), .lo_q(lo_q), .cal_busy(cal_busy),
   .pll_locked(pll_locked));
`default_nettype wire

// File: lsp_pll_control_tb.sv
// bench: register access, lo decode, detector sense, calibration and lock
// assumes the host model drives the serial pins; vco stand-in is gated by the bench
`timescale 1ns/1ps
`default_nettype none
module lsp_pll_control_tb;
   import lsp_pkg::*;
   localparam int CAL = 20;
   logic        clk_sys, rst, ref_clk_in, vco_clk_in, ext_lo_in, vco_run;
   logic        sclk, cs_n, host_sdo, sdio_o, sdio_oe_n, lo_i, lo_q;
   logic        int_mode, cal_busy, pll_locked, mon;
   lsp_pump_s   pump;
   lsp_lo_ctl_s lo_ctl;
   int          mismatches, checks_done, n;
   wire logic   sdio = sdio_oe_n ? host_sdo : sdio_o;
   logic [6:0]  addrs [7] = '{ADDR_LO_EN, ADDR_WHOLE, ADDR_NUM, ADDR_DEN, ADDR_REFMON,
                              ADDR_LOPATH, ADDR_TRIM};
   lsp_host_model u_lsp_host_model (.sclk(sclk), .cs_n(cs_n), .sdo(host_sdo), .sdi(sdio));
   lsp_pll_control #(.CAL_PFD_CYCLES(CAL), .LOCK_PFD_CYCLES(8'h04)) u_lsp_pll_control (
      .clk_sys(clk_sys), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdio_i(sdio),
      .spi_sdio_o(sdio_o), .spi_sdio_oe_n(sdio_oe_n), .ref_clk_in(ref_clk_in),
      .vco_clk_in(vco_clk_in), .ext_lo_in(ext_lo_in), .pump(pump), .lo_ctl(lo_ctl),
      .lo_i(lo_i), .lo_q(lo_q), .int_mode(int_mode), .cal_busy(cal_busy),
      .pll_locked(pll_locked), .monitor_output_pin(mon));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      ref_clk_in = 1'b0;
      forever #200 ref_clk_in = ~ref_clk_in;
   end
   // vco at twice the reference rate so an integer ratio of one balances the detector
   initial
   begin
      vco_clk_in = 1'b0;
      ext_lo_in = 1'b0;
      #50;
      forever #100 vco_clk_in = vco_run & ~vco_clk_in;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] q;
      @(posedge clk_sys);
      #1 u_lsp_host_model.xfer(1'b0, a, d, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] q;
      @(posedge clk_sys);
      #1 u_lsp_host_model.xfer(1'b1, a, 16'h0000, q);
      check(q, e);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #600000;
      mismatches++;
      conclude();
   end
   initial
   begin
      rst = 1'b1;
      vco_run = 1'b0;
      mismatches = 0;
      checks_done = 0;
      repeat (10) @(posedge clk_sys);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk_sys) #1;
      check(16'(int_mode), 16'h0000);
      foreach (addrs[i])
      begin
         rd(addrs[i], 16'h0000);
         wr(addrs[i], 16'h14b4 ^ 16'(addrs[i]));
         rd(addrs[i], 16'h14b4 ^ 16'(addrs[i]));
      end
      wr(7'h10, 16'hffff);
      rd(7'h10, 16'h0000);
      for (int c = 0; c < 5; c++)
      begin
         wr(ADDR_LOPATH, 16'({c[1:0], 1'b0, c[1:0], c[2:0]}));
         check(16'(lo_ctl.vco_core_en), c[2] ? 16'h0000 : 16'h0008 >> c[1:0]);
         check(16'(lo_ctl.ext_lo_mode), 16'(c[2]));
         check(16'({lo_ctl.lo_output_drive_level, lo_ctl.lo_halving_stage_two_enable,
            lo_ctl.lo_halving_stage_one_enable}), 16'({c[1:0], c[1:0]}));
      end
      wr(ADDR_LOPATH, 16'h0018);
      wr(ADDR_LO_EN, 16'h027e);
      check(16'({lo_ctl.quad_div_en, lo_ctl.lo_enables}), 16'h00fe);
      wr(ADDR_TRIM, 16'h14b4);
      wr(ADDR_REFMON, 16'h0000);
      repeat (160) @(posedge clk_sys) #1;
      check(16'(pump), 16'h0002);
      wr(ADDR_REFMON, 16'h0008);
      check(16'(pump), 16'h0001);
      wr(ADDR_WHOLE, 16'h0801);
      check(16'({int_mode, cal_busy, pll_locked}), 16'h0006);
      n = 0;
      while (cal_busy !== 1'b0 && n < 2000) @(posedge clk_sys) #1 n++;
      check(16'(n inside {[CAL * 16 - 24:CAL * 16 + 8]}), 16'h0001);
      // vco starts only now so the divider reloads with the final ratio, 150 ns behind ref
      @(posedge ref_clk_in) #60 vco_run = 1'b1;
      n = 0;
      while (pll_locked !== 1'b1 && n < 1000) @(posedge clk_sys) #1 n++;
      check(16'({pll_locked, mon}), 16'h0003);
      @(posedge lo_i) n = 0;
      while (lo_i === 1'b1 && n < 200) @(posedge clk_sys) #1 n++;
      check(16'(n inside {[31:33]}), 16'h0001);
      wr(ADDR_REFMON, 16'h0013);
      @(posedge mon) n = 0;
      while (mon === 1'b1 && n < 200) @(posedge clk_sys) #1 n++;
      check(16'(n inside {[63:65]}), 16'h0001);
      wr(ADDR_REFMON, 16'h0038);
      check(16'(mon), 16'h0000);
      wr(ADDR_NUM, 16'h0000);
      check(16'({mon, pll_locked}), 16'h0002);
      conclude();
   end
endmodule
`default_nettype wire

// File: lsp_serial_port.sv
// serial register port: 7 address bits, read flag, 16 data bits, msb first
// assumes sclk, cs_n and sdio come straight from pins
`timescale 1ns/1ps
`default_nettype none
module lsp_serial_port
   import lsp_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            sclk,
   input  wire logic            cs_n,
   input  wire logic            sdio_i,
   output logic                 sdio_o,
   output logic                 sdio_oe_n,
   output logic [6:0]           rd_addr,
   input  wire logic [15:0]     rd_data,
   output logic                 wr_valid,
   output var lsp_pkg::lsp_wr_s wr
);
   import lsp_pkg::*;

   typedef struct packed
   {
      logic [2:0]  sck;
      logic [2:0]  cs;
      logic [2:0]  sdi;
      lsp_spi_e    st;
      logic [2:0]  cnt;
      logic [6:0]  addr;
      logic        rw;
      logic [15:0] sh;
      logic [4:0]  nd;
      logic [15:0] dout;
      logic        drv;
      logic        wr;
   } lsp_spi_st_s;

   lsp_spi_st_s q, n;

   always_comb
   begin
      n     = q;
      n.wr  = 1'b0;
      n.sck = {q.sck[1:0], sclk};
      n.cs  = {q.cs[1:0], cs_n};
      n.sdi = {q.sdi[1:0], sdio_i};
      case (q.st)
         SPI_IDLE:
         begin
            n.drv = 1'b0;
            if (sig_fall(q.cs))
            begin
               n.st  = SPI_ADDR;
               n.cnt = 3'h0;
               n.nd  = 5'h00;
               // a short write must not pick up bits left from an earlier frame
               n.sh  = 16'h0000;
            end
         end
         SPI_ADDR:
         begin
            if (sig_rise(q.cs))
               n.st = SPI_IDLE;
            else if (sig_rise(q.sck))
            begin
               if (q.cnt == 3'(ADDR_BITS))
               begin
                  n.rw = q.sdi[1];
                  n.st = SPI_DATA;
               end
               else
               begin
                  n.addr = {q.addr[5:0], q.sdi[1]};
                  n.cnt  = q.cnt + 3'h1;
               end
            end
         end
         SPI_DATA:
         begin
            if (sig_rise(q.cs))
            begin
               n.st  = SPI_IDLE;
               n.drv = 1'b0;
               // partial word: the bits that arrived land at the low end, all higher bits are written as zero
               n.wr  = ~q.rw & (q.nd != 5'h00);
            end
            else if (sig_rise(q.sck) && !q.rw)
            begin
               n.sh = {q.sh[14:0], q.sdi[1]};
               if (q.nd != 5'(DATA_BITS))
                  n.nd = q.nd + 5'h01;
            end
            else if (sig_fall(q.sck) && q.rw)
            begin
               if (!q.drv)
               begin
                  n.dout = rd_data;
                  n.drv  = 1'b1;
               end
               else
                  n.dout = {q.dout[14:0], 1'b0};
            end
         end
         default:
            n.st = SPI_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         q     <= '0;
         q.sck <= 3'h0;
         q.cs  <= 3'h7;
         q.st  <= SPI_IDLE;
      end
      else
         q <= n;
   end

   assign sdio_o    = q.dout[15];
   assign sdio_oe_n = ~q.drv;
   assign rd_addr   = q.addr;
   assign wr_valid  = q.wr;
   assign wr.addr   = q.addr;
   assign wr.data   = q.sh;

endmodule
`default_nettype wire
